// ==== design/lsb_pkg.sv ====
package lsb_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int SINKS     = 7;
	localparam int MAIN_CNT  = 4;
	localparam int CODE_W    = 6;
	localparam int CUR_W     = 10;
	localparam int ADDR_W    = 3;
	localparam int DATA_W    = 8;

	// ****************************************
	// Sink index map
	// ****************************************
	localparam int SINK_FIFTH = 4;
	localparam int SINK_SUB1  = 5;
	localparam int SINK_SUB2  = 6;

	// ****************************************
	// Device register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFS_ENABLE = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_SUB    = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_MAIN   = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_AUX    = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_FAULT  = 3'h4;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int EN_DETECT_BIT  = 6;
	localparam int EN_MAIN_BIT    = 5;
	localparam int EN_SUB2_BIT    = 4;
	localparam int EN_SUB1_BIT    = 3;
	localparam int EN_AUX_BIT     = 2;
	localparam int ROLE_HI_BIT    = 1;
	localparam int ROLE_LO_BIT    = 0;
	localparam int AUX_CODE_LSB   = 2;
	localparam int AUX_LVL_HI_BIT = 3;
	localparam int AUX_LVL_LO_BIT = 2;

	// ****************************************
	// Reset values and role codes
	// ****************************************
	localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
	localparam logic [1:0]        ROLE_MAIN = 2'h1;
	localparam logic [1:0]        ROLE_AUX  = 2'h2;

	// ****************************************
	// Current scale, microamps
	// ****************************************
	localparam int CUR_UNIT_UA    = 100;
	localparam int FINE_LAST      = 15;
	localparam int COARSE_FIRST   = 16;
	localparam int COARSE_BASE_UA = 2000;
	localparam int COARSE_STEP_UA = 500;
	localparam int AUX_FULL_UA    = 80000;
	localparam int PCT_L0         = 20;
	localparam int PCT_L1         = 40;
	localparam int PCT_L2         = 70;
	localparam int PCT_L3         = 100;

	// ****************************************
	// Host controller register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] HOFS_CTRL  = 3'h0;
	localparam logic [ADDR_W-1:0] HOFS_ADDR  = 3'h1;
	localparam logic [ADDR_W-1:0] HOFS_WDATA = 3'h2;
	localparam logic [ADDR_W-1:0] HOFS_CMD   = 3'h3;
	localparam logic [ADDR_W-1:0] HOFS_RDATA = 3'h4;
	localparam logic [ADDR_W-1:0] HOFS_STAT  = 3'h5;
	localparam int CTRL_HWEN_BIT = 0;
	localparam int CMD_WR_BIT    = 0;
	localparam int CMD_RD_BIT    = 1;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [CUR_W-1:0] code2cur(input logic [CODE_W-1:0] code);
		int c;
		c = int'(code);
		if (c <= FINE_LAST) begin
			code2cur = CUR_W'(c);
		end else begin
			code2cur = CUR_W'((COARSE_BASE_UA + (c - COARSE_FIRST) * COARSE_STEP_UA)
				/ CUR_UNIT_UA);
		end
	endfunction

	function automatic logic [CUR_W-1:0] aux_level(input logic [1:0] sel);
		int pct;
		unique case (sel)
			2'h0: pct = PCT_L0;
			2'h1: pct = PCT_L1;
			2'h2: pct = PCT_L2;
			2'h3: pct = PCT_L3;
		endcase
		aux_level = CUR_W'((AUX_FULL_UA / CUR_UNIT_UA) * pct / 100);
	endfunction

endpackage

// ==== design/lsb_if.sv ====
interface lsb_if;
	import lsb_pkg::*;

	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic              hw_en;

	modport dev (
		input  reg_addr,
		input  reg_wdata,
		input  reg_wr,
		input  reg_rd,
		input  hw_en,
		output reg_rdata
	);

	modport host (
		output reg_addr,
		output reg_wdata,
		output reg_wr,
		output reg_rd,
		output hw_en,
		input  reg_rdata
	);

endinterface

// ==== design/lsb_sync.sv ====
module lsb_sync
	import lsb_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ****************************************
	// Two-stage synchroniser
	// ****************************************
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// ==== design/lsb_dev.sv ====
// Implementation choices: the plain strobed port and the register offsets.
module lsb_dev
	import lsb_pkg::*;
(
	input  wire logic                         sys_clk,
	input  wire logic                         reset,
	lsb_if.dev                                link,
	input  wire logic [SINKS-1:0]             open_det,
	output logic      [SINKS-1:0]             sink_on,
	output logic      [SINKS-1:0][CUR_W-1:0]  sink_target,
	output logic                              chip_active
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic             hw_en_s;
	logic [SINKS-1:0] open_s;

	lsb_sync #(.WIDTH(1)) u_sync_en (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in (link.hw_en),
		.sync_out (hw_en_s)
	);

	lsb_sync #(.WIDTH(SINKS)) u_sync_open (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in (open_det),
		.sync_out (open_s)
	);

	// ****************************************
	// Registers
	// ****************************************
	logic [DATA_W-1:0] enable_r;
	logic [DATA_W-1:0] sub_cur_r;
	logic [DATA_W-1:0] main_cur_r;
	logic [DATA_W-1:0] aux_cur_r;
	logic [SINKS-1:0]  fault_r;
	logic [SINKS-1:0]  fault_nxt;
	logic [DATA_W-1:0] rdata_r;
	logic [SINKS-1:0]  sink_on_nxt;
	logic [SINKS-1:0][CUR_W-1:0] target_nxt;

	// ****************************************
	// Write decode
	// ****************************************
	wire wr_enable = link.reg_wr && (link.reg_addr == OFS_ENABLE);
	wire wr_sub    = link.reg_wr && (link.reg_addr == OFS_SUB);
	wire wr_main   = link.reg_wr && (link.reg_addr == OFS_MAIN);
	wire wr_aux    = link.reg_wr && (link.reg_addr == OFS_AUX);

	// ****************************************
	// Register file
	// ****************************************
	// Pin low forces zeros and swallows writes
	// Writes within two cycles of the pin rising are lost to sync lag
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			enable_r   <= REG_RESET;
			sub_cur_r  <= REG_RESET;
			main_cur_r <= REG_RESET;
			aux_cur_r  <= REG_RESET;
		end else if (!hw_en_s) begin
			enable_r   <= REG_RESET;
			sub_cur_r  <= REG_RESET;
			main_cur_r <= REG_RESET;
			aux_cur_r  <= REG_RESET;
		end else begin
			if (wr_enable) begin
				enable_r <= link.reg_wdata;
			end
			if (wr_sub) begin
				sub_cur_r <= link.reg_wdata;
			end
			if (wr_main) begin
				main_cur_r <= link.reg_wdata;
			end
			if (wr_aux) begin
				aux_cur_r <= link.reg_wdata;
			end
		end
	end

	// ****************************************
	// Role and enable decode
	// ****************************************
	wire [1:0] role = {enable_r[ROLE_HI_BIT], enable_r[ROLE_LO_BIT]};
	wire aux_role = (role == ROLE_AUX);
	// Roles 00 and 11 stop outputs but keep stored settings
	wire sw_run = (role == ROLE_MAIN) || aux_role;
	// Pin is synced, so a pin drop reaches the sinks three edges late
	wire run = hw_en_s && sw_run;
	wire detect_en = enable_r[EN_DETECT_BIT];

	// ****************************************
	// Current targets
	// ****************************************
	wire [CODE_W-1:0] main_code  = main_cur_r[CODE_W-1:0];
	wire [CODE_W-1:0] sub_code   = sub_cur_r[CODE_W-1:0];
	// Fifth sink in main role reuses the aux code bits
	wire [CODE_W-1:0] fifth_code = aux_cur_r[AUX_CODE_LSB +: CODE_W];
	wire [1:0] aux_sel = {aux_cur_r[AUX_LVL_HI_BIT], aux_cur_r[AUX_LVL_LO_BIT]};

	wire [CUR_W-1:0] main_cur = code2cur(main_code);
	wire [CUR_W-1:0] sub_cur  = code2cur(sub_code);
	// Upper aux bits are don't-care in aux role
	wire [CUR_W-1:0] fifth_cur = aux_role ? aux_level(aux_sel)
		: code2cur(fifth_code);

	// Zero code means zero target, so the sink stays off
	wire main_want  = run && enable_r[EN_MAIN_BIT] && (main_cur != '0);
	wire fifth_want = run && enable_r[EN_AUX_BIT] && (fifth_cur != '0);
	wire sub1_want  = run && enable_r[EN_SUB1_BIT] && (sub_cur != '0);
	wire sub2_want  = run && enable_r[EN_SUB2_BIT] && (sub_cur != '0);

	wire [SINKS-1:0] want = {sub2_want, sub1_want, fifth_want, {MAIN_CNT{main_want}}};

	// ****************************************
	// Open-lamp shutdown
	// ****************************************
	// Fault latches off the sink; a lamp that reads closed again
	// only returns after detection is toggled or the chip restarts
	always_comb begin
		if (!detect_en || !run) begin
			fault_nxt = '0;
		end else begin
			fault_nxt = fault_r | (open_s & want);
		end
	end

	always_comb begin
		sink_on_nxt = want & ~fault_nxt;
		for (int i = 0; i < SINKS; i++) begin
			target_nxt[i] = '0;
		end
		for (int i = 0; i < MAIN_CNT; i++) begin
			target_nxt[i] = sink_on_nxt[i] ? main_cur : '0;
		end
		target_nxt[SINK_FIFTH] = sink_on_nxt[SINK_FIFTH] ? fifth_cur : '0;
		target_nxt[SINK_SUB1]  = sink_on_nxt[SINK_SUB1] ? sub_cur : '0;
		target_nxt[SINK_SUB2]  = sink_on_nxt[SINK_SUB2] ? sub_cur : '0;
	end

	// ****************************************
	// Output stage
	// ****************************************
	// Registered so every sink pin comes straight from a flop
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			fault_r     <= '0;
			sink_on     <= '0;
			sink_target <= '0;
			chip_active <= 1'b0;
		end else begin
			fault_r     <= fault_nxt;
			sink_on     <= sink_on_nxt;
			sink_target <= target_nxt;
			chip_active <= run;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Unused top bit of the fault word reads as zero
	wire [DATA_W-1:0] rd_value =
		(link.reg_addr == OFS_ENABLE) ? enable_r :
		(link.reg_addr == OFS_SUB)    ? sub_cur_r :
		(link.reg_addr == OFS_MAIN)   ? main_cur_r :
		(link.reg_addr == OFS_AUX)    ? aux_cur_r :
		(link.reg_addr == OFS_FAULT)  ? {1'b0, fault_r} :
		REG_RESET;

	// Data stand one cycle only, zero otherwise
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= link.reg_rd ? rd_value : '0;
		end
	end

	assign link.reg_rdata = rdata_r;

endmodule

// ==== design/lsb_host.sv ====
module lsb_host
	import lsb_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              reset,
	lsb_if.host                    link,
	input  wire logic [ADDR_W-1:0] cmd_addr,
	input  wire logic [DATA_W-1:0] cmd_wdata,
	input  wire logic              cmd_wr,
	input  wire logic              cmd_rd,
	output logic      [DATA_W-1:0] cmd_rdata
);

	// ****************************************
	// Controller registers
	// ****************************************
	logic              hw_en_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wdata_r;
	logic              bus_wr_r;
	logic              bus_rd_r;
	logic              rd_pend_r;
	logic [DATA_W-1:0] dev_data_r;

	wire wr_ctrl  = cmd_wr && (cmd_addr == HOFS_CTRL);
	wire wr_addr  = cmd_wr && (cmd_addr == HOFS_ADDR);
	wire wr_wdata = cmd_wr && (cmd_addr == HOFS_WDATA);
	wire wr_cmd   = cmd_wr && (cmd_addr == HOFS_CMD);
	wire busy     = bus_wr_r || bus_rd_r || rd_pend_r;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hw_en_r    <= 1'b0;
			addr_r     <= '0;
			wdata_r    <= '0;
			bus_wr_r   <= 1'b0;
			bus_rd_r   <= 1'b0;
			rd_pend_r  <= 1'b0;
			dev_data_r <= '0;
		end else begin
			if (wr_ctrl) begin
				hw_en_r <= cmd_wdata[CTRL_HWEN_BIT];
			end
			if (wr_addr) begin
				addr_r <= cmd_wdata[ADDR_W-1:0];
			end
			if (wr_wdata) begin
				wdata_r <= cmd_wdata;
			end
			// Write wins if software sets both
			bus_wr_r  <= wr_cmd && cmd_wdata[CMD_WR_BIT];
			bus_rd_r  <= wr_cmd && cmd_wdata[CMD_RD_BIT] && !cmd_wdata[CMD_WR_BIT];
			rd_pend_r <= bus_rd_r;
			if (rd_pend_r) begin
				dev_data_r <= link.reg_rdata;
			end
		end
	end

	assign link.hw_en     = hw_en_r;
	assign link.reg_addr  = addr_r;
	assign link.reg_wdata = wdata_r;
	assign link.reg_wr    = bus_wr_r;
	assign link.reg_rd    = bus_rd_r;

	// ****************************************
	// Command read path
	// ****************************************
	wire [DATA_W-1:0] cmd_value =
		(cmd_addr == HOFS_CTRL)  ? {7'h00, hw_en_r} :
		(cmd_addr == HOFS_ADDR)  ? {5'h00, addr_r} :
		(cmd_addr == HOFS_WDATA) ? wdata_r :
		(cmd_addr == HOFS_RDATA) ? dev_data_r :
		(cmd_addr == HOFS_STAT)  ? {7'h00, busy} :
		8'h00;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cmd_rdata <= '0;
		end else begin
			cmd_rdata <= cmd_rd ? cmd_value : '0;
		end
	end

endmodule

// ==== verification/lsb_props.sv ====
module lsb_props
	import lsb_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              hw_en
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Shadow of the device registers
	// ****************************************
	logic [3:0][DATA_W-1:0] shadow_r;
	logic [2:0]             hi_cnt_r;
	logic [DATA_W-1:0]      sel_shadow;
	logic                   det_off;
	logic                   wr_ok;

	// Writes near the pin edge are skipped: the sync lag makes them uncertain
	assign wr_ok      = reg_wr && (hi_cnt_r >= 3'h3) && (reg_addr < OFS_FAULT);
	assign sel_shadow = shadow_r[reg_addr[1:0]];
	assign det_off    = !shadow_r[0][EN_DETECT_BIT];

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			hi_cnt_r <= 3'h0;
		end else if (!hw_en) begin
			hi_cnt_r <= 3'h0;
		end else if (hi_cnt_r != 3'h7) begin
			hi_cnt_r <= hi_cnt_r + 3'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			shadow_r <= '0;
		end else if (!hw_en) begin
			shadow_r <= '0;
		end else if (wr_ok) begin
			shadow_r[reg_addr[1:0]] <= reg_wdata;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence s_pin_off;
		!hw_en [*5];
	endsequence

	sequence s_known_rd;
		reg_rd && (reg_addr < OFS_FAULT) && (hi_cnt_r >= 3'h3);
	endsequence

	a_rdata_idle_zero: assert property ((reg_rdata != 8'h00) |-> $past(reg_rd))
		else $error("read data outside answer cycle");
	a_strobe_exclusive: assert property (!(reg_wr && reg_rd))
		else $error("write and read strobes together");
	a_read_gap: assert property (reg_rd |=> !reg_rd [*2])
		else $error("device read issued while busy");
	a_reg_readback: assert property (s_known_rd |=> reg_rdata == $past(sel_shadow))
		else $error("register read back differs from written");
	a_pin_low_clears: assert property (s_pin_off ##0 reg_rd |=> reg_rdata == 8'h00)
		else $error("register not cleared with pin low");
	a_unmapped_zero: assert property (reg_rd && (reg_addr > OFS_FAULT) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_fault_width: assert property (reg_rd && (reg_addr == OFS_FAULT) |=> !reg_rdata[7])
		else $error("fault bit above seventh sink");
	a_fault_clear: assert property (reg_rd && (reg_addr == OFS_FAULT) && det_off
		&& $past(det_off, 3) |=> reg_rdata == 8'h00)
		else $error("fault latched with detection off");
endmodule

// ==== verification/led_sink_bank_control_tb_top.sv ====
module led_sink_bank_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lsb_pkg::*;

	logic                        sys_clk;
	logic                        reset;
	logic [ADDR_W-1:0]           cmd_addr;
	logic [DATA_W-1:0]           cmd_wdata;
	logic                        cmd_wr;
	logic                        cmd_rd;
	logic [DATA_W-1:0]           cmd_rdata;
	logic [SINKS-1:0]            open_det;
	logic [SINKS-1:0]            sink_on;
	logic [SINKS-1:0][CUR_W-1:0] sink_target;
	logic                        chip_active;
	int                          err_count;
	int                          cmp_count;

	lsb_if u_lsb_if ();
	lsb_dev u_lsb_dev (.sys_clk(sys_clk), .reset(reset), .link(u_lsb_if), .open_det(open_det),
		.sink_on(sink_on), .sink_target(sink_target), .chip_active(chip_active));
	lsb_host u_lsb_host (.sys_clk(sys_clk), .reset(reset), .link(u_lsb_if), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
	lsb_props u_lsb_props (.sys_clk(sys_clk), .reset(reset), .reg_addr(u_lsb_if.reg_addr),
		.reg_wdata(u_lsb_if.reg_wdata), .reg_wr(u_lsb_if.reg_wr), .reg_rd(u_lsb_if.reg_rd),
		.reg_rdata(u_lsb_if.reg_rdata), .hw_en(u_lsb_if.hw_en));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic end_of_test;
		$display("compares=%0d mismatches=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cwr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge sys_clk);
		cmd_wr <= 1'b0;
	endtask

	task automatic crd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge sys_clk);
		cmd_rd <= 1'b0;
		#1 d = cmd_rdata;
	endtask

	// Bounded poll: a stuck busy flag ends the run
	task automatic wait_idle;
		logic [DATA_W-1:0] s;
		int                n;
		for (n = 0; n < 20; n++) begin
			crd(HOFS_STAT, s);
			if (s[0] === 1'b0) break;
		end
		if (n == 20) begin
			err_count++;
			end_of_test;
		end
	endtask

	task automatic dev_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		cwr(HOFS_ADDR, {5'h00, a});
		cwr(HOFS_WDATA, d);
		cwr(HOFS_CMD, 8'h01);
		wait_idle;
	endtask

	task automatic dev_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		cwr(HOFS_ADDR, {5'h00, a});
		cwr(HOFS_CMD, 8'h02);
		wait_idle;
		crd(HOFS_RDATA, d);
	endtask

	task automatic pin(input logic v);
		cwr(HOFS_CTRL, {7'h00, v});
		repeat (6) @(posedge sys_clk);
		#1;
	endtask

	task automatic settle;
		repeat (5) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic [15:0] exp_cur(input int c);
		if (c == 0) return 16'h0000;
		if (c <= 15) return 16'(c);
		return 16'(20 + (c - 16) * 5);
	endfunction

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_codes;
		int codes[6] = '{0, 1, 15, 16, 17, 63};
		pin(1'b1);
		dev_wr(OFS_ENABLE, 8'h3D);
		foreach (codes[k]) begin
			dev_wr(OFS_MAIN, 8'(codes[k]));
			dev_wr(OFS_SUB, 8'(63 - codes[k]));
			dev_wr(OFS_AUX, 8'(codes[k] << 2));
			settle;
			chk(16'(sink_target[0]), exp_cur(codes[k]));
			chk(16'(sink_target[3]), exp_cur(codes[k]));
			chk(16'(sink_target[SINK_SUB1]), exp_cur(63 - codes[k]));
			chk(16'(sink_target[SINK_FIFTH]), exp_cur(codes[k]));
			chk(16'(sink_on[SINK_SUB2]), 16'(codes[k] != 63));
		end
		$display("t_codes done");
	endtask

	task automatic t_aux;
		int pct[4] = '{20, 40, 70, 100};
		dev_wr(OFS_ENABLE, 8'h06);
		for (int s = 0; s < 4; s++) begin
			dev_wr(OFS_AUX, {4'hF, 2'(s), 2'h0});
			settle;
			chk(16'(sink_target[SINK_FIFTH]), 16'(pct[s] * 8));
			chk(16'(sink_on[SINK_FIFTH]), 16'h0001);
			chk(16'(sink_on[0]), 16'h0000);
			chk(16'(chip_active), 16'h0001);
		end
		$display("t_aux done");
	endtask

	task automatic t_open;
		logic [DATA_W-1:0] d;
		dev_wr(OFS_MAIN, 8'h0A);
		dev_wr(OFS_ENABLE, 8'h21);
		@(posedge sys_clk);
		open_det <= 7'h02;
		settle;
		chk(16'(sink_on[1]), 16'h0001);
		dev_wr(OFS_ENABLE, 8'h61);
		settle;
		chk(16'(sink_on[1:0]), 16'h0001);
		dev_rd(OFS_FAULT, d);
		chk(16'(d), 16'h0002);
		@(posedge sys_clk);
		open_det <= 7'h00;
		settle;
		chk(16'(sink_on[1]), 16'h0000);
		dev_wr(OFS_ENABLE, 8'h21);
		settle;
		chk(16'(sink_on[1]), 16'h0001);
		$display("t_open done");
	endtask

	task automatic t_soft;
		logic [DATA_W-1:0] d;
		dev_wr(OFS_SUB, 8'h05);
		dev_wr(OFS_ENABLE, 8'h11);
		settle;
		chk(16'(sink_on[SINK_SUB2:SINK_SUB1]), 16'h0002);
		chk(16'(sink_target[SINK_SUB2]), 16'h0005);
		dev_wr(OFS_ENABLE, 8'h09);
		settle;
		chk(16'(sink_on[SINK_SUB2:SINK_SUB1]), 16'h0001);
		dev_wr(OFS_ENABLE, 8'h20);
		settle;
		chk(16'({chip_active, sink_on}), 16'h0000);
		dev_rd(OFS_MAIN, d);
		chk(16'(d), 16'h000A);
		dev_wr(OFS_ENABLE, 8'h23);
		settle;
		chk(16'({chip_active, sink_on}), 16'h0000);
		dev_rd(OFS_ENABLE, d);
		chk(16'(d), 16'h0023);
		dev_rd(OFS_FAULT, d);
		chk(16'(d), 16'h0000);
		dev_rd(3'h5, d);
		chk(16'(d), 16'h0000);
		$display("t_soft done");
	endtask

	task automatic t_pin;
		logic [DATA_W-1:0] d;
		dev_wr(OFS_ENABLE, 8'h21);
		settle;
		chk(16'(sink_on[0]), 16'h0001);
		chk(16'(sink_on[SINK_FIFTH]), 16'h0000);
		pin(1'b0);
		chk(16'({chip_active, sink_on}), 16'h0000);
		dev_wr(OFS_ENABLE, 8'h21);
		settle;
		chk(16'(sink_on), 16'h0000);
		dev_rd(OFS_MAIN, d);
		chk(16'(d), 16'h0000);
		pin(1'b1);
		dev_rd(OFS_ENABLE, d);
		chk(16'(d), 16'h0000);
		$display("t_pin done");
	endtask

	// ****************************************
	// Clock and sequence
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	initial begin
		reset = 1'b1;
		cmd_addr = 3'h0;
		cmd_wdata = 8'h00;
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		open_det = 7'h00;
		err_count = 0;
		cmp_count = 0;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		t_codes;
		t_aux;
		t_open;
		t_soft;
		t_pin;
		end_of_test;
	end
endmodule
